// *** pie_pkg.sv ***
// Purpose: Constants for the peripheral interrupt enable bank
// Assumes: 32-bit classic Wishbone slave, byte addresses
// Notes: Enable registers are 8 bits wide, held in the low byte
package pie_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_EN_A = 8'h00;
	localparam logic [7:0] OFF_EN_B = 8'h04;
	localparam logic [7:0] OFF_EN_C = 8'h08;
	localparam logic [7:0] OFF_CORE = 8'h0C;
	localparam logic [7:0] OFF_STAT = 8'h10;
	localparam int ADR_LSB = 2;
	// Reset values and writable masks
	localparam logic [7:0] RST_EN = 8'h00;
	localparam logic [7:0] MASK_A = 8'hFF;
	localparam logic [7:0] MASK_B = 8'hEF;
	localparam logic [7:0] MASK_C = 8'h7F;
	localparam logic [7:0] MASK_CORE = 8'hC0;
	// First enable register
	localparam int A_TMR1_GATE = 7;
	localparam int A_ADC = 6;
	localparam int A_SER_RX = 5;
	localparam int A_SER_TX = 4;
	localparam int A_SSP = 3;
	localparam int A_CAP1 = 2;
	localparam int A_TMR2 = 1;
	localparam int A_TMR1_OVF = 0;
	// Second enable register
	localparam int B_OSC_FAIL = 7;
	localparam int B_CMP2 = 6;
	localparam int B_CMP1 = 5;
	localparam int B_UNUSED = 4;
	localparam int B_SSP_COLL = 3;
	localparam int B_TMR6 = 2;
	localparam int B_TMR4 = 1;
	localparam int B_CAP2 = 0;
	// Third enable register
	localparam int C_UNUSED = 7;
	localparam int C_NUM_OSC = 6;
	localparam int C_OUT_GEN = 5;
	localparam int C_ZERO_X = 4;
	localparam int C_CELL4 = 3;
	localparam int C_CELL3 = 2;
	localparam int C_CELL2 = 1;
	localparam int C_CELL1 = 0;
	// Core control and status fields
	localparam int CORE_GLOBAL = 7;
	localparam int CORE_PERIPH = 6;
	localparam int STAT_REQ = 0;
	localparam int STAT_PEND = 1;
endpackage

// *** pie_enable_bank.sv ***
// Purpose: Peripheral interrupt enable bank with gated request to core
// Assumes: Flags arrive synchronous to mclk from the peripherals
// Notes: Wishbone ack one cycle after request; unmapped reads zero
//
// Design decisions made here: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
module pie_enable_bank (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Peripheral flags
	input wire logic [7:0] periph_flags_a,
	input wire logic [7:0] periph_flags_b,
	input wire logic [7:0] periph_flags_c,
	// Request to core
	output logic irq_req
);
	logic [7:0] en_a_q;
	logic [7:0] en_a_d;
	logic [7:0] en_b_q;
	logic [7:0] en_b_d;
	logic [7:0] en_c_q;
	logic [7:0] en_c_d;
	logic [7:0] core_q;
	logic [7:0] core_d;
	logic ack_q;
	logic [31:0] dat_q;
	logic [31:0] dat_d;

	// Bus decode
	wire req_new = wb_cyc_i & wb_stb_i & ~ack_q;
	wire wr_now = wb_cyc_i & wb_stb_i & ack_q & wb_we_i & wb_sel_i[0];
	wire [7:0] adr_word = {wb_adr_i[7:pie_pkg::ADR_LSB],
		{pie_pkg::ADR_LSB{1'b0}}};
	wire hit_a = adr_word == pie_pkg::OFF_EN_A;
	wire hit_b = adr_word == pie_pkg::OFF_EN_B;
	wire hit_c = adr_word == pie_pkg::OFF_EN_C;
	wire hit_core = adr_word == pie_pkg::OFF_CORE;
	wire hit_stat = adr_word == pie_pkg::OFF_STAT;

	// Named enable bits
	wire timer1_gate_acq_en = en_a_q[pie_pkg::A_TMR1_GATE];
	wire adc_done_en = en_a_q[pie_pkg::A_ADC];
	wire serial_rx_en = en_a_q[pie_pkg::A_SER_RX];
	wire serial_tx_en = en_a_q[pie_pkg::A_SER_TX];
	wire sync_serial_en = en_a_q[pie_pkg::A_SSP];
	wire capture_unit1_en = en_a_q[pie_pkg::A_CAP1];
	wire timer2_match_en = en_a_q[pie_pkg::A_TMR2];
	wire timer1_overflow_en = en_a_q[pie_pkg::A_TMR1_OVF];
	wire osc_fail_en = en_b_q[pie_pkg::B_OSC_FAIL];
	wire comparator2_en = en_b_q[pie_pkg::B_CMP2];
	wire comparator1_en = en_b_q[pie_pkg::B_CMP1];
	wire sync_serial_collision_en = en_b_q[pie_pkg::B_SSP_COLL];
	wire timer6_match_en = en_b_q[pie_pkg::B_TMR6];
	wire timer4_match_en = en_b_q[pie_pkg::B_TMR4];
	wire capture_unit2_en = en_b_q[pie_pkg::B_CAP2];
	wire num_osc_en = en_c_q[pie_pkg::C_NUM_OSC];
	wire output_gen_shutdown_en = en_c_q[pie_pkg::C_OUT_GEN];
	wire zero_cross_en = en_c_q[pie_pkg::C_ZERO_X];
	wire logic_cell4_en = en_c_q[pie_pkg::C_CELL4];
	wire logic_cell3_en = en_c_q[pie_pkg::C_CELL3];
	wire logic_cell2_en = en_c_q[pie_pkg::C_CELL2];
	wire logic_cell1_en = en_c_q[pie_pkg::C_CELL1];
	wire global_irq_gate = core_q[pie_pkg::CORE_GLOBAL];
	wire peripheral_irq_gate = core_q[pie_pkg::CORE_PERIPH];

	// Flags pass untouched; enables only mask them
	wire [7:0] masked_a = periph_flags_a & en_a_q;
	wire [7:0] masked_b = periph_flags_b & en_b_q;
	wire [7:0] masked_c = periph_flags_c & en_c_q;
	wire pending_any = |{masked_a, masked_b, masked_c};
	// Both gates in series, so clearing either holds all requests back
	assign irq_req = pending_any & peripheral_irq_gate
		& global_irq_gate;

	// Write path; unimplemented bits masked off at the write
	assign en_a_d = (wr_now & hit_a) ?
		(wb_dat_i[7:0] & pie_pkg::MASK_A) : en_a_q;
	assign en_b_d = (wr_now & hit_b) ?
		(wb_dat_i[7:0] & pie_pkg::MASK_B) : en_b_q;
	assign en_c_d = (wr_now & hit_c) ?
		(wb_dat_i[7:0] & pie_pkg::MASK_C) : en_c_q;
	assign core_d = (wr_now & hit_core) ?
		(wb_dat_i[7:0] & pie_pkg::MASK_CORE) : core_q;

	// Read mux; unmapped offsets read zero
	wire [7:0] stat_val = {6'h00, pending_any, irq_req};
	wire [7:0] rd_byte = hit_a ? en_a_q :
		hit_b ? en_b_q :
		hit_c ? en_c_q :
		hit_core ? core_q :
		hit_stat ? stat_val : 8'h00;
	// Data captured as ack rises so it stands for the whole ack cycle
	assign dat_d = req_new ? {24'h000000, rd_byte} : dat_q;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			en_a_q <= pie_pkg::RST_EN;
			en_b_q <= pie_pkg::RST_EN;
			en_c_q <= pie_pkg::RST_EN;
			core_q <= pie_pkg::RST_EN;
			ack_q <= 1'b0;
			dat_q <= 32'h00000000;
		end else begin
			en_a_q <= en_a_d;
			en_b_q <= en_b_d;
			en_c_q <= en_c_d;
			core_q <= core_d;
			ack_q <= req_new;
			dat_q <= dat_d;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;

	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	sequence s_gates_open;
		global_irq_gate && peripheral_irq_gate;
	endsequence
	sequence s_wr_a;
		wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && hit_a;
	endsequence
	sequence s_wr_b;
		wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && hit_b;
	endsequence
	sequence s_rd_c;
		wb_ack_o && !wb_we_i && hit_c;
	endsequence

	property p_tmr1g_adc;
		s_gates_open ##0 (periph_flags_a[pie_pkg::A_TMR1_GATE] &&
			timer1_gate_acq_en || periph_flags_a[pie_pkg::A_ADC] &&
			adc_done_en) |-> irq_req;
	endproperty
	a_tmr1g_adc: assert property (p_tmr1g_adc)
		else $error("timer1 gate or converter request lost");

	property p_serial;
		s_gates_open ##0 (periph_flags_a[pie_pkg::A_SER_RX] && serial_rx_en
			|| periph_flags_a[pie_pkg::A_SER_TX] && serial_tx_en) |-> irq_req;
	endproperty
	a_serial: assert property (p_serial)
		else $error("serial request lost");

	property p_ssp_cap1;
		s_gates_open ##0 (periph_flags_a[pie_pkg::A_SSP] && sync_serial_en
			|| periph_flags_a[pie_pkg::A_CAP1] && capture_unit1_en)
			|-> irq_req;
	endproperty
	a_ssp_cap1: assert property (p_ssp_cap1)
		else $error("sync serial or capture1 request lost");

	property p_tmr2_tmr1;
		s_gates_open ##0 (periph_flags_a[pie_pkg::A_TMR2] && timer2_match_en
			|| periph_flags_a[pie_pkg::A_TMR1_OVF] && timer1_overflow_en)
			|-> irq_req;
	endproperty
	a_tmr2_tmr1: assert property (p_tmr2_tmr1)
		else $error("timer2 or timer1 overflow request lost");

	property p_osc_fail;
		s_gates_open ##0 periph_flags_b[pie_pkg::B_OSC_FAIL] && osc_fail_en
			|-> irq_req;
	endproperty
	a_osc_fail: assert property (p_osc_fail)
		else $error("oscillator fail request lost");

	property p_cmp;
		s_gates_open ##0 (periph_flags_b[pie_pkg::B_CMP2] && comparator2_en
			|| periph_flags_b[pie_pkg::B_CMP1] && comparator1_en) |-> irq_req;
	endproperty
	a_cmp: assert property (p_cmp)
		else $error("comparator request lost");

	property p_collision;
		s_gates_open ##0 periph_flags_b[pie_pkg::B_SSP_COLL] &&
			sync_serial_collision_en |-> irq_req;
	endproperty
	a_collision: assert property (p_collision)
		else $error("bus collision request lost");

	property p_tmr64;
		s_gates_open ##0 (periph_flags_b[pie_pkg::B_TMR6] && timer6_match_en
			|| periph_flags_b[pie_pkg::B_TMR4] && timer4_match_en) |-> irq_req;
	endproperty
	a_tmr64: assert property (p_tmr64)
		else $error("timer6 or timer4 request lost");

	property p_cap2_write;
		s_wr_b |=> capture_unit2_en == $past(wb_dat_i[pie_pkg::B_CAP2]);
	endproperty
	a_cap2_write: assert property (p_cap2_write)
		else $error("capture2 enable not stored");

	property p_num_osc;
		s_gates_open ##0 periph_flags_c[pie_pkg::C_NUM_OSC] && num_osc_en
			|-> irq_req;
	endproperty
	a_num_osc: assert property (p_num_osc)
		else $error("numeric oscillator request lost");

	property p_out_gen;
		s_gates_open ##0 periph_flags_c[pie_pkg::C_OUT_GEN] &&
			output_gen_shutdown_en |-> irq_req;
	endproperty
	a_out_gen: assert property (p_out_gen)
		else $error("output generator request lost");

	property p_zero_x;
		s_gates_open ##0 periph_flags_c[pie_pkg::C_ZERO_X] && zero_cross_en
			|-> irq_req;
	endproperty
	a_zero_x: assert property (p_zero_x)
		else $error("zero-cross request lost");

	property p_cells;
		s_gates_open ##0 (periph_flags_c[pie_pkg::C_CELL4] && logic_cell4_en
			|| periph_flags_c[pie_pkg::C_CELL3] && logic_cell3_en
			|| periph_flags_c[pie_pkg::C_CELL2] && logic_cell2_en
			|| periph_flags_c[pie_pkg::C_CELL1] && logic_cell1_en)
			|-> irq_req;
	endproperty
	a_cells: assert property (p_cells)
		else $error("logic cell request lost");

	property p_periph_gate;
		!peripheral_irq_gate |-> !irq_req;
	endproperty
	a_periph_gate: assert property (p_periph_gate)
		else $error("request while peripheral gate closed");

	property p_reset_zero;
		!$past(reset_n) |-> en_a_q == pie_pkg::RST_EN &&
			en_b_q == pie_pkg::RST_EN && en_c_q == pie_pkg::RST_EN;
	endproperty
	a_reset_zero: assert property (p_reset_zero)
		else $error("enable not zero after reset");

	property p_unused_zero;
		en_b_q[pie_pkg::B_UNUSED] == 1'b0 && en_c_q[pie_pkg::C_UNUSED] == 1'b0;
	endproperty
	a_unused_zero: assert property (p_unused_zero)
		else $error("unimplemented enable bit set");

	property p_no_spurious;
		irq_req |-> pending_any;
	endproperty
	a_no_spurious: assert property (p_no_spurious)
		else $error("request without a masked flag");

	property p_global_gate;
		!global_irq_gate |-> !irq_req;
	endproperty
	a_global_gate: assert property (p_global_gate)
		else $error("request while global gate closed");

	property p_masked_only;
		irq_req |-> (|masked_a || |masked_b || |masked_c);
	endproperty
	a_masked_only: assert property (p_masked_only)
		else $error("request not explained by flag and enable");

	property p_write_next;
		s_wr_a |=> en_a_q == $past(wb_dat_i[7:0]) ##1 !wb_ack_o;
	endproperty
	a_write_next: assert property (p_write_next)
		else $error("first enable write not stored");

	property p_read_c;
		s_rd_c |-> wb_dat_o == {24'h000000, en_c_q};
	endproperty
	a_read_c: assert property (p_read_c)
		else $error("third enable read mismatch");
endmodule

// *** pie_flag_src.sv ***
// Purpose: Peripheral flag sources feeding the enable bank
// Assumes: Bench raises and clears flags on mclk
// Notes: Flags are sticky until clear_all wipes them; a raise in the same cycle still lands
`timescale 1ns/1ps
module pie_flag_src (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// Bench control
	input wire logic [23:0] raise,
	input wire logic clear_all,
	// Flags to the bank
	output logic [7:0] flags_a,
	output logic [7:0] flags_b,
	output logic [7:0] flags_c
);
	logic [23:0] flags_q;
	// No enable input here: flags record events whatever the masks hold
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			flags_q <= 24'h000000;
		else
			flags_q <= (clear_all ? 24'h000000 : flags_q) | raise;
	end
	assign flags_a = flags_q[7:0];
	assign flags_b = flags_q[15:8];
	assign flags_c = flags_q[23:16];
endmodule

// *** pie_enable_bank_tb.sv ***
// Purpose: Self-checking bench for the interrupt enable bank
// Assumes: Wishbone ack arrives within a few cycles
// Notes: Expected request is rebuilt from masks and gates
`timescale 1ns/1ps
module pie_enable_bank_tb;
	logic mclk = 1'b0, reset_n = 1'b0, cyc = 1'b0, stb = 1'b0;
	logic we = 1'b0, clr = 1'b0, ack, irq_req;
	logic [7:0] adr = 8'h00, fa, fb, fc, a, bb, c, g;
	logic [3:0] sel = 4'h0;
	logic [31:0] dw = 32'h00000000, rd, dat_o;
	logic [23:0] raise = 24'h000000, f;
	int fails = 0, comparisons = 0, r, b, k;
	localparam logic [7:0] OFFS [3] = '{pie_pkg::OFF_EN_A,
		pie_pkg::OFF_EN_B, pie_pkg::OFF_EN_C};
	localparam logic [7:0] MSK [3] = '{pie_pkg::MASK_A,
		pie_pkg::MASK_B, pie_pkg::MASK_C};
	always #10 mclk = ~mclk;
	pie_enable_bank dut (.mclk(mclk), .reset_n(reset_n), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(dw), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.periph_flags_a(fa), .periph_flags_b(fb), .periph_flags_c(fc),
		.irq_req(irq_req));
	pie_flag_src src (.mclk(mclk), .reset_n(reset_n), .raise(raise),
		.clear_all(clr), .flags_a(fa), .flags_b(fb), .flags_c(fc));
	function automatic logic exp_irq(logic [23:0] fl, logic [7:0] ea,
		logic [7:0] eb, logic [7:0] ec, logic [7:0] gt);
		return (|({ec & pie_pkg::MASK_C, eb & pie_pkg::MASK_B, ea} & fl))
			& gt[pie_pkg::CORE_GLOBAL] & gt[pie_pkg::CORE_PERIPH];
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("comparisons=%0d fails=%0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Request held steady until ack is sampled, released at that edge
	task automatic xfer(input logic w, input logic [7:0] ad,
		input logic [31:0] d, input logic [3:0] s);
		int n;
		n = 0;
		@(posedge mclk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= ad;
		dw <= d;
		sel <= s;
		do begin
			@(posedge mclk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (n >= 50)
			check(32'h00000001, 32'h00000000);
		rd = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] ad, input logic [7:0] d);
		xfer(1'b1, ad, {24'h000000, d}, 4'hF);
	endtask
	task automatic rdchk(input logic [7:0] ad, input logic [7:0] e);
		xfer(1'b0, ad, 32'h00000000, 4'hF);
		check(rd, {24'h000000, e});
	endtask
	// Old flags are wiped in the same cycle the new ones land
	task automatic set_flags(input logic [23:0] v);
		@(posedge mclk);
		clr <= 1'b1;
		raise <= v;
		@(posedge mclk);
		clr <= 1'b0;
		raise <= 24'h000000;
		@(negedge mclk);
	endtask
	task automatic irq_is(input logic e);
		check({31'h0, irq_req}, {31'h0, e});
	endtask
	initial begin
		#400000;
		fails++;
		tally_and_finish();
	end
	initial begin
		void'($urandom(32'hAE93));
		repeat (2) @(posedge mclk);
		reset_n <= 1'b1;
		for (r = 0; r < 3; r++)
			rdchk(OFFS[r], 8'h00);
		for (r = 0; r < 3; r++) begin
			for (k = 0; k < 4; k++) begin
				a = (k == 0) ? 8'hFF : (k == 1) ? 8'h00 : 8'($urandom);
				wr(OFFS[r], a);
				rdchk(OFFS[r], a & MSK[r]);
			end
			wr(OFFS[r], 8'h00);
		end
		xfer(1'b1, pie_pkg::OFF_EN_A, 32'h000000FF, 4'h0);
		rdchk(pie_pkg::OFF_EN_A, 8'h00);
		wr(8'h40, 8'hFF);
		rdchk(8'h40, 8'h00);
		wr(pie_pkg::OFF_CORE, 8'hC0);
		// Single enable against its own flag, then against all others
		for (r = 0; r < 3; r++) begin
			for (b = 0; b < 8; b++) begin
				wr(OFFS[r], 8'h01 << b);
				set_flags(24'h000001 << (8 * r + b));
				irq_is(MSK[r][b]);
				irq_is(MSK[r][b]);
				irq_is(MSK[r][b]);
				set_flags(~(24'h000001 << (8 * r + b)));
				irq_is(1'b0);
				wr(OFFS[r], 8'h00);
			end
		end
		// Global gate off: flag stays, request follows once gate returns
		wr(pie_pkg::OFF_CORE, 8'h40);
		wr(pie_pkg::OFF_EN_B, 8'h80);
		set_flags(24'h008000);
		irq_is(1'b0);
		wr(pie_pkg::OFF_CORE, 8'hC0);
		@(negedge mclk);
		irq_is(1'b1);
		wr(pie_pkg::OFF_CORE, 8'h80);
		@(negedge mclk);
		irq_is(1'b0);
		repeat (40) begin
			a = 8'($urandom);
			bb = 8'($urandom);
			c = 8'($urandom);
			g = 8'($urandom) & 8'hC0;
			f = 24'($urandom);
			wr(pie_pkg::OFF_EN_A, a);
			wr(pie_pkg::OFF_EN_B, bb);
			wr(pie_pkg::OFF_EN_C, c);
			wr(pie_pkg::OFF_CORE, g);
			set_flags(f);
			irq_is(exp_irq(f, a, bb, c, g));
			rdchk(pie_pkg::OFF_CORE, g);
			// Status: ungated pending above the gated request
			rdchk(pie_pkg::OFF_STAT, {6'h00, exp_irq(f, a, bb, c, 8'hC0),
				exp_irq(f, a, bb, c, g)});
		end
		@(posedge mclk);
		reset_n <= 1'b0;
		@(posedge mclk);
		reset_n <= 1'b1;
		for (r = 0; r < 3; r++)
			rdchk(OFFS[r], 8'h00);
		set_flags(24'hFFFFFF);
		irq_is(1'b0);
		tally_and_finish();
	end
endmodule
